// file: logic/vme_port_consts.svh
`ifndef VME_PORT_CONSTS_SVH
`define VME_PORT_CONSTS_SVH

// Register offsets within the block
`define OFS_DATA 4'h1
`define OFS_DONE 4'h3
`define OFS_ENABLE 4'h5
`define OFS_STATUS 4'h7
`define OFS_VECTOR 4'h9

// Enable register fields
`define EN_MASTER 7
`define EN_TX 6
`define EN_RX 5
`define EN_DONE 4

// AM bits compared; bit 2 is the privilege bit
`define AM_CMP_MASK 6'h3B

// Board initialisation time
`define INIT_TIME_MS 1500
`define CLK_PERIOD_NS 8
`define INIT_CYCLES (`INIT_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define INIT_W 28

`endif

// file: logic/vme_port_pkg.sv
package vme_port_pkg;

	// Bus pins seen by the slave
	typedef struct packed {
		logic as_n;
		logic ds0_n;
		logic ds1_n;
		logic write_n;
		logic lword_n;
		logic iack_n;
		logic iackin_n;
		logic sysreset_n;
		logic [5:0] am;
		logic [15:1] addr;
		logic [7:0] data;
	} vme_in_type;

	// Static board switches, bit value 1 = switch off
	typedef struct packed {
		logic [15:4] base;
		logic [5:0] am_sel;
		logic [2:0] level;
		logic [7:1] line_sel;
	} switch_type;

	// Events from the on-board processor
	typedef struct packed {
		logic resp_valid;
		logic [7:0] resp_byte;
		logic tx_room;
		logic done_set;
		logic [3:0] done_axes;
		logic overtravel;
		logic encoder_err;
		logic cmd_err;
	} board_event_type;

	typedef enum {CYC_IDLE, CYC_ACK, CYC_PASS} cycle_state_type;

endpackage

// file: logic/vme_short_io_host_port.sv
`timescale 1ns/1ps
`include "vme_port_consts.svh"

module vme_short_io_host_port
	import vme_port_pkg::*;
#(
	parameter logic [`INIT_W-1:0] INIT_CYCLES = `INIT_W'(`INIT_CYCLES)
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire vme_in_type vme_in,
	input wire switch_type sw_in,
	input wire board_event_type board_ev,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic dtack_oe,
	output logic [7:1] irq_oe,
	output logic iackout_n,
	output logic [7:0] host_byte,
	output logic host_byte_valid,
	output logic board_init
);

	localparam int PIN_W = $bits(vme_in_type) + $bits(switch_type);

	////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_f;
	wire [PIN_W-1:0] pin_raw;
	wire [PIN_W-1:0] pin_agree;
	wire [PIN_W-1:0] next_pin_f;
	vme_in_type bus;
	switch_type sw;

	assign pin_raw = {vme_in, sw_in};
	assign pin_agree = ~(pin_s2 ^ pin_s3);

	// A bit moves only once stages two and three agree
	assign next_pin_f = (pin_s3 & pin_agree) | (pin_f & ~pin_agree);

	// Three stage chain, all pins at once
	always_ff @(posedge clk)
	begin
		pin_s1 <= pin_raw;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	// Filtered copy, idle bus after reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_f <= '1;
		end
		else
		begin
			pin_f <= next_pin_f;
		end
	end

	assign {bus, sw} = pin_f;

	////////////////////////////////////////////////////////////////
	// Address and cycle decode

	wire strobe_odd;
	wire am_ok;
	wire base_hit;
	wire [3:0] offset;
	wire data_cycle;
	wire hit_cycle;
	wire is_write;
	wire is_read;
	wire iack_cycle;
	wire level_hit;

	// Odd byte: DS0 only, no long word
	assign strobe_odd = ~bus.as_n & ~bus.ds0_n & bus.ds1_n
		& bus.lword_n;

	// Privilege bit ignored so both modes pass
	assign am_ok = ((bus.am ^ sw.am_sel) & `AM_CMP_MASK)
		== 6'h00;

	// Switch bit value 1 = off, compared to A15..A4
	assign base_hit = bus.addr[15:4] == sw.base;

	assign offset = {bus.addr[3:1], 1'b1};
	assign data_cycle = strobe_odd & bus.iack_n;
	assign hit_cycle = data_cycle & am_ok & base_hit;

	// Write line alone chooses direction
	assign is_write = hit_cycle & ~bus.write_n;
	assign is_read = hit_cycle & bus.write_n;

	// Acknowledge cycles carry the level on A3..A1
	assign iack_cycle = ~bus.as_n & ~bus.ds0_n & ~bus.iack_n;
	assign level_hit = bus.addr[3:1] == sw.level;

	////////////////////////////////////////////////////////////////
	// Bus cycle state machine

	cycle_state_type state;
	cycle_state_type next_state;
	logic take;
	logic take_iack;

	wire irq_req;

	// Pick the response for each new strobe
	always_comb
	begin
		next_state = state;
		take = 1'b0;
		take_iack = 1'b0;
		case (state)
			CYC_IDLE:
			begin
				if (iack_cycle && !bus.iackin_n)
				begin
					if (level_hit && irq_req)
					begin
						next_state = CYC_ACK;
						take_iack = 1'b1;
					end
					else
					begin
						next_state = CYC_PASS;
					end
				end
				else if (hit_cycle)
				begin
					next_state = CYC_ACK;
					take = 1'b1;
				end
			end
			CYC_ACK:
			begin
				if (bus.ds0_n || bus.as_n)
				begin
					next_state = CYC_IDLE;
				end
			end
			CYC_PASS:
			begin
				if (bus.as_n)
				begin
					next_state = CYC_IDLE;
				end
			end
			default:
			begin
				next_state = CYC_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= CYC_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	wire rd_take;
	wire wr_take;
	wire wr_data;
	wire wr_enable;
	wire wr_vector;
	wire rd_data;
	wire rd_done;
	wire rd_status;

	assign rd_take = take & is_read;
	assign wr_take = take & is_write;
	assign wr_data = wr_take & (offset == `OFS_DATA);
	assign wr_enable = wr_take & (offset == `OFS_ENABLE);
	assign wr_vector = wr_take & (offset == `OFS_VECTOR);
	assign rd_data = rd_take & (offset == `OFS_DATA);
	assign rd_done = rd_take & (offset == `OFS_DONE);
	assign rd_status = rd_take & (offset == `OFS_STATUS);

	////////////////////////////////////////////////////////////////
	// Registers

	logic [7:4] enables;
	logic [7:0] vector;
	logic [7:0] rx_byte;
	logic [3:0] done_flags;
	logic tx_empty_flag;
	logic rx_full_flag;
	logic done_error_flag;
	logic overtravel_flag;
	logic encoder_flag;
	logic cmd_flag;
	wire [7:0] status_byte;
	wire [7:0] enable_byte;

	// Enables write through at once
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			enables <= 4'h0;
		end
		else if (wr_enable)
		begin
			enables <= bus.data[7:4];
		end
	end

	// Vector byte kept for acknowledge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			vector <= 8'h00;
		end
		else if (wr_vector)
		begin
			vector <= bus.data;
		end
	end

	// Response byte from the board
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_byte <= 8'h00;
		end
		else if (board_ev.resp_valid)
		begin
			rx_byte <= board_ev.resp_byte;
		end
	end

	// Command byte handed to the board
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			host_byte <= 8'h00;
			host_byte_valid <= 1'b0;
		end
		else
		begin
			host_byte_valid <= wr_data;
			if (wr_data)
			begin
				host_byte <= bus.data;
			end
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_empty_flag <= 1'b0;
			rx_full_flag <= 1'b0;
			done_error_flag <= 1'b0;
			overtravel_flag <= 1'b0;
			encoder_flag <= 1'b0;
			cmd_flag <= 1'b0;
			done_flags <= 4'h0;
		end
		else
		begin
			tx_empty_flag <= board_ev.tx_room
				| (tx_empty_flag & ~wr_data);
			rx_full_flag <= board_ev.resp_valid
				| (rx_full_flag & ~rd_data);
			done_error_flag <= board_ev.done_set
				| board_ev.overtravel | board_ev.encoder_err
				| board_ev.cmd_err
				| (done_error_flag & ~rd_status);
			overtravel_flag <= board_ev.overtravel
				| (overtravel_flag & ~rd_status);
			encoder_flag <= board_ev.encoder_err
				| (encoder_flag & ~rd_status);
			cmd_flag <= board_ev.cmd_err
				| (cmd_flag & ~rd_status);
			done_flags <= (board_ev.done_set ? board_ev.done_axes
				: 4'h0) | (done_flags & {4{~rd_done}});
		end
	end

	////////////////////////////////////////////////////////////////
	// On-board reset timer

	logic [`INIT_W-1:0] init_count;
	logic sysreset_seen;

	// Reset pin only restarts the timer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			init_count <= INIT_CYCLES;
			sysreset_seen <= 1'b0;
		end
		else
		begin
			sysreset_seen <= ~bus.sysreset_n;
			if (~bus.sysreset_n && !sysreset_seen)
			begin
				init_count <= INIT_CYCLES;
			end
			else if (init_count != '0)
			begin
				init_count <= init_count - `INIT_W'(1);
			end
		end
	end

	assign board_init = init_count != '0;

	////////////////////////////////////////////////////////////////
	// Read data and interrupt request

	assign status_byte = {
		tx_empty_flag | rx_full_flag | done_error_flag,
		tx_empty_flag,
		rx_full_flag,
		done_error_flag,
		overtravel_flag,
		encoder_flag,
		board_init,
		cmd_flag
	};

	assign enable_byte = {enables, 4'h0};

	logic [7:0] read_byte;

	// Read mux, unused offsets give zero
	always_comb
	begin
		case (offset)
			`OFS_DATA: read_byte = rx_byte;
			`OFS_DONE: read_byte = {4'h0, done_flags};
			`OFS_ENABLE: read_byte = enable_byte;
			`OFS_STATUS: read_byte = status_byte;
			`OFS_VECTOR: read_byte = vector;
			default: read_byte = 8'h00;
		endcase
	end

	// Master enable gates each enabled source
	assign irq_req = enables[`EN_MASTER]
		& ((enables[`EN_TX] & tx_empty_flag)
		| (enables[`EN_RX] & rx_full_flag)
		| (enables[`EN_DONE] & done_error_flag));

	// Only the line picked by the line switches pulls low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_oe <= 7'h00;
		end
		else
		begin
			irq_oe <= sw.line_sel & {7{irq_req}};
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus drivers

	// Data and acknowledge held until strobe release
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			data_out <= 8'h00;
			data_oe <= 1'b0;
			dtack_oe <= 1'b0;
		end
		else
		begin
			if (take_iack)
			begin
				data_out <= vector;
			end
			else if (rd_take)
			begin
				data_out <= read_byte;
			end
			data_oe <= (next_state == CYC_ACK)
				& (bus.write_n | take_iack | (state == CYC_ACK
				& data_oe));
			dtack_oe <= next_state == CYC_ACK;
		end
	end

	// Daisy chain passes acknowledges not for us
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			iackout_n <= 1'b1;
		end
		else
		begin
			iackout_n <= next_state != CYC_PASS;
		end
	end

endmodule

// file: sim/vme_port_monitor.sv
`timescale 1ns/1ps
module vme_port_monitor
	import vme_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire vme_in_type vme_in,
	input wire switch_type sw_in,
	input wire board_event_type board_ev,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic dtack_oe,
	input wire logic [7:1] irq_oe,
	input wire logic iackout_n,
	input wire logic [7:0] host_byte,
	input wire logic host_byte_valid,
	input wire logic board_init
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic dt_q;
	// First acknowledge cycle and register reads
	wire take = dtack_oe && !dt_q;
	wire rd = take && vme_in.write_n && vme_in.iack_n;
	wire [2:0] sel = vme_in.addr[3:1];
	// Acknowledge one cycle back
	always_ff @(posedge clk)
		dt_q <= dtack_oe;
	// Decode, direction and read field checks
	chk_odd_byte: assert property (
		take |-> vme_in.ds1_n && vme_in.lword_n)
		else $error("ack on even or wide cycle");
	chk_base_hit: assert property (
		take && vme_in.iack_n |-> vme_in.addr[15:4] == sw_in.base)
		else $error("ack outside block");
	chk_am_match: assert property (
		take && vme_in.iack_n
		|-> ((vme_in.am ^ sw_in.am_sel) & 6'h3B) == 6'h00)
		else $error("ack on wrong modifier");
	chk_read_drive: assert property (
		take |-> data_oe == vme_in.write_n)
		else $error("data drive against direction");
	chk_ack_release: assert property (
		$rose(vme_in.ds0_n) && dtack_oe |-> ##[1:6] !dtack_oe)
		else $error("ack held after strobe release");
	chk_byte_pulse: assert property (
		host_byte_valid
		|-> take && !vme_in.write_n && sel == 3'h0 ##1 !host_byte_valid)
		else $error("bad host byte pulse");
	chk_status_or: assert property (
		rd && sel == 3'h3 |-> data_out[7] == |data_out[6:4])
		else $error("status summary bit wrong");
	chk_done_high: assert property (
		rd && sel == 3'h1 |-> data_out[7:4] == 4'h0)
		else $error("done upper nibble set");
	chk_enable_low: assert property (
		rd && sel == 3'h2 |-> data_out[3:0] == 4'h0)
		else $error("enable lower nibble set");
	chk_unused_zero: assert property (
		rd && sel > 3'h4 |-> data_out == 8'h00)
		else $error("unused offset not zero");
	chk_irq_line: assert property (
		(irq_oe & ~sw_in.line_sel) == 7'h00)
		else $error("request on unselected line");
	// Main scenarios reached
	cover property (host_byte_valid);
	cover property (take && !vme_in.iack_n);
	cover property (irq_oe != 7'h00);
	cover property (!iackout_n);
endmodule
bind vme_short_io_host_port vme_port_monitor mon_u (.clk, .rst_n, .vme_in,
	.sw_in, .board_ev, .data_out, .data_oe, .dtack_oe, .irq_oe, .iackout_n,
	.host_byte, .host_byte_valid, .board_init);

// file: sim/vme_host_model.sv
`timescale 1ns/1ps
module vme_host_model
	import vme_port_pkg::*;
(
	input wire logic clk,
	output vme_in_type vme_in,
	input wire logic dtack_oe,
	input wire logic [7:0] data_out
);
	// Bus idle, all strobes released
	initial
		vme_in = '1;
	// One byte cycle, held until acknowledge is sampled or 20 clocks pass
	task automatic cyc(input logic wr, input logic iak, input logic [5:0] am,
		input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rv,
		output logic ack);
		int n;
		@(negedge clk);
		vme_in.am = am;
		vme_in.addr = a[15:1];
		vme_in.write_n = !wr;
		vme_in.iack_n = !iak;
		vme_in.iackin_n = !iak;
		vme_in.data = wr ? wd : ~vme_in.data;
		vme_in.as_n = 1'b0;
		vme_in.ds0_n = !a[0];
		vme_in.ds1_n = a[0];
		ack = 1'b0;
		n = 0;
		while (!ack && n < 20)
		begin
			@(posedge clk);
			ack = dtack_oe;
			rv = data_out;
			n++;
		end
		@(negedge clk);
		vme_in.as_n = 1'b1;
		vme_in.ds0_n = 1'b1;
		vme_in.ds1_n = 1'b1;
		vme_in.write_n = 1'b1;
		vme_in.iack_n = 1'b1;
		vme_in.iackin_n = 1'b1;
		vme_in.data = ~vme_in.data;
		n = 0;
		// Keep strobes high long enough for the pin filter to see it
		while ((dtack_oe || n < 3) && n < 12)
		begin
			@(posedge clk);
			n++;
		end
	endtask
endmodule

// file: sim/vme_short_io_host_port_tb.sv
`timescale 1ns/1ps
module vme_short_io_host_port_tb
	import vme_port_pkg::*;
	;
	logic clk;
	logic rst_n;
	vme_in_type vme_in;
	switch_type sw_in;
	board_event_type board_ev;
	logic [7:0] data_out, host_byte, got_byte, v;
	logic data_oe, dtack_oe, iackout_n, host_byte_valid, board_init, ack;
	logic [7:1] irq_oe;
	logic chain_low;
	int fail_count = 0;
	int checked = 0;
	vme_short_io_host_port #(.INIT_CYCLES(28'h14)) dut_u (.clk, .rst_n,
		.vme_in, .sw_in, .board_ev, .data_out, .data_oe, .dtack_oe, .irq_oe,
		.iackout_n, .host_byte, .host_byte_valid, .board_init);
	vme_host_model model_u (.clk, .vme_in, .dtack_oe, .data_out);
	// Clock
	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end
	// Last host byte handed on
	always @(posedge clk)
		if (host_byte_valid)
			got_byte <= host_byte;
	// Daisy chain seen passing an acknowledge on
	always @(posedge clk)
		if (!rst_n)
			chain_low <= 1'b0;
		else if (!iackout_n)
			chain_low <= 1'b1;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [3:0] o, input logic [7:0] d);
		model_u.cyc(wr, 1'b0, 6'h29, {12'hFF8, o}, d, v, ack);
		chk({7'h00, ack}, 8'h01);
	endtask
	task automatic rdc(input logic [3:0] o, input logic [7:0] exp);
		acc(1'b0, o, 8'h00);
		chk(v, exp);
	endtask
	task automatic pulse(input board_event_type e);
		@(negedge clk);
		board_ev = e;
		@(negedge clk);
		board_ev = '0;
	endtask
	task automatic t_init();
		chk({7'h00, board_init}, 8'h01);
		for (int i = 0; i < 60 && board_init; i++)
			@(negedge clk);
		chk({7'h00, board_init}, 8'h00);
		model_u.vme_in.sysreset_n = 1'b0;
		for (int i = 0; i < 10 && !board_init; i++)
			@(negedge clk);
		model_u.vme_in.sysreset_n = 1'b1;
		chk({7'h00, board_init}, 8'h01);
		for (int i = 0; i < 60 && board_init; i++)
			@(negedge clk);
		chk({7'h00, board_init}, 8'h00);
	endtask
	task automatic t_regs();
		acc(1'b1, 4'h5, 8'hFF);
		rdc(4'h5, 8'hF0);
		acc(1'b1, 4'h9, 8'hA5);
		rdc(4'h9, 8'hA5);
		acc(1'b1, 4'hB, 8'h55);
		rdc(4'hB, 8'h00);
		rdc(4'hF, 8'h00);
		rdc(4'h3, 8'h00);
	endtask
	task automatic t_refuse();
		model_u.cyc(1'b0, 1'b0, 6'h29, 16'hFF82, 8'h00, v, ack);
		chk({7'h00, ack}, 8'h00);
		model_u.cyc(1'b0, 1'b0, 6'h09, 16'hFF81, 8'h00, v, ack);
		chk({7'h00, ack}, 8'h00);
		model_u.cyc(1'b0, 1'b0, 6'h29, 16'hFF91, 8'h00, v, ack);
		chk({7'h00, ack}, 8'h00);
		model_u.cyc(1'b0, 1'b0, 6'h2D, 16'hFF85, 8'h00, v, ack);
		chk({7'h00, ack}, 8'h01);
	endtask
	task automatic t_data();
		pulse('{tx_room:1'b1, default:'0});
		rdc(4'h7, 8'hC0);
		rdc(4'h5, 8'hF0);
		acc(1'b1, 4'h1, 8'h57);
		chk(got_byte, 8'h57);
		rdc(4'h7, 8'h00);
		pulse('{resp_valid:1'b1, resp_byte:8'h0A, default:'0});
		rdc(4'h7, 8'hA0);
		rdc(4'h1, 8'h0A);
		rdc(4'h7, 8'h00);
	endtask
	task automatic t_done();
		pulse('{done_set:1'b1, done_axes:4'hA, default:'0});
		rdc(4'h3, 8'h0A);
		rdc(4'h3, 8'h00);
		rdc(4'h7, 8'h90);
		rdc(4'h7, 8'h00);
		pulse('{encoder_err:1'b1, cmd_err:1'b1, default:'0});
		rdc(4'h7, 8'h95);
		rdc(4'h7, 8'h00);
	endtask
	task automatic t_irq();
		acc(1'b1, 4'h5, 8'h90);
		pulse('{overtravel:1'b1, default:'0});
		for (int i = 0; i < 10 && irq_oe == 7'h00; i++)
			@(negedge clk);
		chk({irq_oe, 1'b0}, 8'h20);
		model_u.cyc(1'b0, 1'b1, 6'h29, 16'h0007, 8'h00, v, ack);
		chk({7'h00, ack}, 8'h00);
		chk({7'h00, chain_low}, 8'h01);
		repeat (6)
			@(negedge clk);
		chk({7'h00, iackout_n}, 8'h01);
		model_u.cyc(1'b0, 1'b1, 6'h29, 16'h000B, 8'h00, v, ack);
		chk(v, 8'hA5);
		rdc(4'h7, 8'h98);
		repeat (4)
			@(negedge clk);
		chk({irq_oe, 1'b0}, 8'h00);
	endtask
	task automatic finish_test();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (6000)
			@(posedge clk);
		fail_count++;
		finish_test();
	end
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		board_ev = '0;
		sw_in = '{base:12'hFF8, am_sel:6'h29, level:3'h5, line_sel:7'h10};
		repeat (12)
			@(negedge clk);
		rst_n = 1'b1;
		t_init();
		t_regs();
		t_refuse();
		t_data();
		t_done();
		t_irq();
		finish_test();
	end
endmodule
